//--- design/dmac_regs.svh
// Constants of the six-channel DMA controller
`ifndef DMAC_REGS_SVH
`define DMAC_REGS_SVH

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define DMAC_NCH 6
`define DMAC_AW 16
`define DMAC_ADDR_RST 16'h0000
`define DMAC_CNT_RST 16'h0000

// ----------------------------------------------------------------
// Field positions of the per-channel mode inputs
// ----------------------------------------------------------------
`define DMAC_TM_CONT_BIT 0
`define DMAC_TM_RPT_BIT 1
`define DMAC_DM_SRCP_BIT 0
`define DMAC_DM_DSTP_BIT 1

// ----------------------------------------------------------------
// Interrupt vector numbers per channel
// ----------------------------------------------------------------
`define DMAC_VEC_CH0 7'h04
`define DMAC_VEC_CH1 7'h0e
`define DMAC_VEC_CH2 7'h18
`define DMAC_VEC_CH3 7'h24
`define DMAC_VEC_CH4 7'h2e
`define DMAC_VEC_CH5 7'h3d

`endif

//--- design/dmac_pkg.sv
// Types of the six-channel DMA controller
package dmac_pkg;
    // Address generation modes
    typedef enum logic [2:0] {AM_FIX, AM_INC, AM_DEC, AM_INCR, AM_PIND} dmac_am_e;
    // Transfer engine states
    typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_LAT, ST_WQ, ST_WR, ST_NUL} dmac_st_e;
endpackage

//--- design/dmac_ch_if.sv
// Link between the transfer engine and one channel
`timescale 1ns/1ps
interface dmac_ch_if;
    logic arm;
    logic trig;
    logic cont;
    logic rpt;
    logic wsize;
    logic [2:0] sam;
    logic [2:0] dam;
    logic [15:0] src0;
    logic [15:0] dst0;
    logic [15:0] cnt0;
    logic [15:0] poff;
    logic req;
    logic [15:0] src;
    logic [15:0] dst;
    logic step;
    logic abort;
    logic done_p;
    logic half_p;
    logic err_p;
    modport ctl (output arm, trig, cont, rpt, wsize, sam, dam, src0, dst0, cnt0, poff,
                 step, abort, input req, src, dst, done_p, half_p, err_p);
    modport ch (input arm, trig, cont, rpt, wsize, sam, dam, src0, dst0, cnt0, poff,
                step, abort, output req, src, dst, done_p, half_p, err_p);
endinterface

//--- design/dmac_chan.sv
// One DMA channel: pointers, transaction counter and trigger state
`timescale 1ns/1ps
`include "dmac_regs.svh"
module dmac_chan (
    input wire logic clk_i,      // System clock
    input wire logic sys_rst_i,  // Async reset, high
    dmac_ch_if.ch ch             // Engine side
);
    logic arm_r, arm_nxt, pen_r, pen_nxt, run_r, run_nxt, prv_r, prv_nxt;
    logic done_r, done_nxt, half_r, half_nxt, err_r, err_nxt;
    logic [15:0] src_r, src_nxt, dst_r, dst_nxt, cnt_r, cnt_nxt, inc, nxt;

    function automatic logic [15:0] adv(input logic [15:0] a, input logic [2:0] m,
                                        input logic [15:0] s);
        case (dmac_pkg::dmac_am_e'(m))
            dmac_pkg::AM_INC, dmac_pkg::AM_INCR: adv = a + s;
            dmac_pkg::AM_DEC: adv = a - s;
            default: adv = a;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        inc = ch.wsize ? 16'h0002 : 16'h0001;
        nxt = cnt_r + 16'h0001;
        arm_nxt = arm_r;
        pen_nxt = pen_r;
        run_nxt = run_r;
        src_nxt = src_r;
        dst_nxt = dst_r;
        cnt_nxt = cnt_r;
        prv_nxt = ch.arm;
        done_nxt = 1'b0;
        half_nxt = 1'b0;
        err_nxt = 1'b0;
        if (!ch.arm) begin
            arm_nxt = 1'b0;
            pen_nxt = 1'b0;
            run_nxt = 1'b0;
        end else if (!prv_r) begin
            arm_nxt = 1'b1;
            src_nxt = ch.src0;
            dst_nxt = ch.dst0;
            cnt_nxt = `DMAC_CNT_RST;
            pen_nxt = 1'b0;
            run_nxt = 1'b0;
        end else begin
            if (ch.abort && arm_r) begin
                err_nxt = 1'b1;
                arm_nxt = 1'b0;
                run_nxt = 1'b0;
                pen_nxt = 1'b0;
            end else if (ch.step && arm_r) begin
                src_nxt = adv(src_r, ch.sam, inc);
                dst_nxt = adv(dst_r, ch.dam, inc);
                cnt_nxt = nxt;
                pen_nxt = 1'b0;
                run_nxt = ch.cont;
                if (nxt == {1'b0, ch.cnt0[15:1]}) begin
                    half_nxt = 1'b1;
                end
                if (nxt == ch.cnt0) begin
                    done_nxt = 1'b1;
                    run_nxt = 1'b0;
                    cnt_nxt = `DMAC_CNT_RST;
                    arm_nxt = ch.rpt;
                    if (dmac_pkg::dmac_am_e'(ch.sam) == dmac_pkg::AM_INCR) begin
                        src_nxt = ch.src0;
                    end
                    if (dmac_pkg::dmac_am_e'(ch.dam) == dmac_pkg::AM_INCR) begin
                        dst_nxt = ch.dst0;
                    end
                end
            end
            // trigger set wins over step clear
            if (ch.trig && arm_nxt) begin
                pen_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arm_r <= 1'b0;
            pen_r <= 1'b0;
            run_r <= 1'b0;
            prv_r <= 1'b0;
            done_r <= 1'b0;
            half_r <= 1'b0;
            err_r <= 1'b0;
            src_r <= `DMAC_ADDR_RST;
            dst_r <= `DMAC_ADDR_RST;
            cnt_r <= `DMAC_CNT_RST;
        end else begin
            arm_r <= arm_nxt;
            pen_r <= pen_nxt;
            run_r <= run_nxt;
            prv_r <= prv_nxt;
            done_r <= done_nxt;
            half_r <= half_nxt;
            err_r <= err_nxt;
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Indirect mode takes its offset live from the peripheral
    assign ch.src = (dmac_pkg::dmac_am_e'(ch.sam) == dmac_pkg::AM_PIND) ?
                    ch.src0 + ch.poff : src_r;
    assign ch.dst = (dmac_pkg::dmac_am_e'(ch.dam) == dmac_pkg::AM_PIND) ?
                    ch.dst0 + ch.poff : dst_r;
    assign ch.req = arm_r & (pen_r | run_r);
    assign ch.done_p = done_r;
    assign ch.half_p = half_r;
    assign ch.err_p = err_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_HALF_POINT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        half_r && !done_r |-> cnt_r == {1'b0, $past(ch.cnt0[15:1])})
        else $error("half event off the half-way count");
    AST_DONE_RELOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_r |-> cnt_r == `DMAC_CNT_RST && !run_r)
        else $error("counter not reloaded at block end");
    AST_TRIG_REQ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        arm_r && prv_r && ch.arm && ch.trig && !ch.abort && !ch.step |=> ch.req)
        else $error("trigger did not raise a request");
endmodule

//--- design/dmac_core.sv
// Six-channel DMA controller: arbiter, transfer engine, interrupt events
`timescale 1ns/1ps
`include "dmac_regs.svh"
module dmac_core #(
    parameter int N = `DMAC_NCH
) (
    input wire logic clk_i,                 // System clock
    input wire logic sys_rst_i,             // Async reset, high
    input wire logic [N-1:0] ch_en_i,       // Channel enable level
    input wire logic [N-1:0] sw_trig_i,     // Software trigger pulse
    input wire logic [N-1:0] per_trig_i,    // Peripheral trigger pulse
    input wire logic [N-1:0] word_i,        // 1 word, 0 byte
    input wire logic [N-1:0] null_i,        // Null write enable
    input wire logic [N-1:0] hie_i,         // Half-way interrupt enable
    input wire logic [N-1:0][1:0] xmode_i,  // Transfer mode
    input wire logic [N-1:0][1:0] dmode_i,  // Data direction mode
    input wire logic [N-1:0][2:0] sam_i,    // Source address mode
    input wire logic [N-1:0][2:0] dam_i,    // Destination address mode
    input wire logic [N-1:0][15:0] src0_i,  // Source start
    input wire logic [N-1:0][15:0] dst0_i,  // Destination start
    input wire logic [N-1:0][15:0] cnt0_i,  // Transaction count
    input wire logic [N-1:0][15:0] poff_i,  // Indirect offset
    input wire logic [15:0] lim_lo_i,       // Lower SRAM limit
    input wire logic [15:0] lim_hi_i,       // Upper SRAM limit
    input wire logic cpu_per_req_i,         // CPU needs bus next cycle
    input wire logic [15:0] bus_rdata_i,    // Read data, cycle after rd
    output logic [15:0] bus_addr_o,         // Access address
    output logic [15:0] bus_wdata_o,        // Write data
    output logic bus_rd_o,                  // Read strobe
    output logic bus_wr_o,                  // Write strobe
    output logic bus_byte_o,                // Byte access
    output logic bus_per_o,                 // 1 peripheral bus, 0 SRAM
    output logic cpu_own_o,                 // Peripheral bus left to CPU
    output logic [N-1:0] irq_o,             // Per-channel interrupt pulse
    output logic irq_vld_o,                 // Vector valid
    output logic [6:0] irq_vec_o,           // Vector of lowest event
    output logic [N-1:0] lim_err_o          // Limit violation pulse
);
    if (N != `DMAC_NCH) begin : g_chk
        $error("dmac_core serves exactly six channels");
    end

    dmac_pkg::dmac_st_e st_r, st_nxt;
    logic [2:0] ch_r, ch_nxt;
    logic [15:0] dat_r, dat_nxt, addr_r, addr_nxt, wd_r, wd_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt, per_r, per_nxt, byte_r, byte_nxt;
    logic step_r, step_nxt, abort_r, abort_nxt, own_r;
    logic [N-1:0] irq_r, irq_nxt, err_r, err_nxt;
    logic vld_r, vld_nxt;
    logic [6:0] vec_r, vec_nxt;
    logic [N-1:0] req_v, blk_v, done_v, half_v, errp_v;
    logic [N-1:0][15:0] src_a, dst_a;
    logic [3:0] sel;
    logic [3:0] ipk;

    function automatic logic [3:0] pick(input logic [N-1:0] v);
        logic [3:0] r;
        r = 4'h8;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b0, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [6:0] vec_of(input logic [2:0] c);
        case (c)
            3'h0: vec_of = `DMAC_VEC_CH0;
            3'h1: vec_of = `DMAC_VEC_CH1;
            3'h2: vec_of = `DMAC_VEC_CH2;
            3'h3: vec_of = `DMAC_VEC_CH3;
            3'h4: vec_of = `DMAC_VEC_CH4;
            default: vec_of = `DMAC_VEC_CH5;
        endcase
    endfunction

    function automatic logic in_lim(input logic [15:0] a);
        in_lim = (a >= lim_lo_i) && (a <= lim_hi_i);
    endfunction

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    dmac_ch_if chi [N] ();
    for (genvar i = 0; i < N; i++) begin : g_ch
        assign chi[i].arm = ch_en_i[i];
        assign chi[i].trig = sw_trig_i[i] | per_trig_i[i];
        assign chi[i].cont = xmode_i[i][`DMAC_TM_CONT_BIT];
        assign chi[i].rpt = xmode_i[i][`DMAC_TM_RPT_BIT];
        assign chi[i].wsize = word_i[i];
        assign chi[i].sam = sam_i[i];
        assign chi[i].dam = dam_i[i];
        assign chi[i].src0 = src0_i[i];
        assign chi[i].dst0 = dst0_i[i];
        assign chi[i].cnt0 = cnt0_i[i];
        assign chi[i].poff = poff_i[i];
        assign chi[i].step = step_r && (ch_r == 3'(i));
        assign chi[i].abort = abort_r && (ch_r == 3'(i));
        assign req_v[i] = chi[i].req;
        assign src_a[i] = chi[i].src;
        assign dst_a[i] = chi[i].dst;
        assign done_v[i] = chi[i].done_p;
        assign half_v[i] = chi[i].half_p;
        assign errp_v[i] = chi[i].err_p;
        // hold off peripheral work while CPU wants the bus
        assign blk_v[i] = (|dmode_i[i]) & cpu_per_req_i;
        dmac_chan u_chan (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .ch(chi[i])
        );
    end

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        dat_nxt = dat_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        per_nxt = per_r;
        byte_nxt = byte_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        step_nxt = 1'b0;
        abort_nxt = 1'b0;
        sel = pick(req_v & ~blk_v);
        case (st_r)
            dmac_pkg::ST_IDLE: begin
                // Channel state updates one cycle after step or abort
                if (!sel[3] && !step_r && !abort_r) begin
                    ch_nxt = sel[2:0];
                    // SRAM side must stay inside the limits
                    if (!((dmode_i[sel[2:0]][`DMAC_DM_SRCP_BIT] | in_lim(src_a[sel[2:0]])) &&
                          (dmode_i[sel[2:0]][`DMAC_DM_DSTP_BIT] | in_lim(dst_a[sel[2:0]])))) begin
                        abort_nxt = 1'b1;
                    end else begin
                        addr_nxt = src_a[sel[2:0]];
                        per_nxt = dmode_i[sel[2:0]][`DMAC_DM_SRCP_BIT];
                        byte_nxt = ~word_i[sel[2:0]];
                        rd_nxt = 1'b1;
                        st_nxt = dmac_pkg::ST_RD;
                    end
                end
            end
            dmac_pkg::ST_RD: st_nxt = dmac_pkg::ST_LAT;
            dmac_pkg::ST_LAT: begin
                // byte transfers keep the low lane only
                dat_nxt = byte_r ? {8'h00, bus_rdata_i[7:0]} : bus_rdata_i;
                st_nxt = dmac_pkg::ST_WQ;
            end
            dmac_pkg::ST_WQ: begin
                if (!(dmode_i[ch_r][`DMAC_DM_DSTP_BIT] && cpu_per_req_i)) begin
                    addr_nxt = dst_a[ch_r];
                    wd_nxt = dat_r;
                    per_nxt = dmode_i[ch_r][`DMAC_DM_DSTP_BIT];
                    wr_nxt = 1'b1;
                    st_nxt = dmac_pkg::ST_WR;
                end
            end
            dmac_pkg::ST_WR: begin
                if (!null_i[ch_r]) begin
                    step_nxt = 1'b1;
                    st_nxt = dmac_pkg::ST_IDLE;
                end else if (!cpu_per_req_i) begin
                    // dummy write back to the source peripheral
                    addr_nxt = src_a[ch_r];
                    wd_nxt = 16'h0000;
                    per_nxt = 1'b1;
                    wr_nxt = 1'b1;
                    st_nxt = dmac_pkg::ST_NUL;
                end
            end
            dmac_pkg::ST_NUL: begin
                step_nxt = 1'b1;
                st_nxt = dmac_pkg::ST_IDLE;
            end
            default: st_nxt = dmac_pkg::ST_IDLE;
        endcase
        irq_nxt = done_v | (half_v & hie_i);
        ipk = pick(irq_nxt);
        vld_nxt = !ipk[3];
        vec_nxt = ipk[3] ? vec_r : vec_of(ipk[2:0]);
        err_nxt = errp_v;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= dmac_pkg::ST_IDLE;
            ch_r <= 3'h0;
            dat_r <= 16'h0000;
            addr_r <= `DMAC_ADDR_RST;
            wd_r <= 16'h0000;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            per_r <= 1'b0;
            byte_r <= 1'b0;
            step_r <= 1'b0;
            abort_r <= 1'b0;
            own_r <= 1'b0;
            irq_r <= '0;
            vld_r <= 1'b0;
            vec_r <= 7'h00;
            err_r <= '0;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            dat_r <= dat_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            per_r <= per_nxt;
            byte_r <= byte_nxt;
            step_r <= step_nxt;
            abort_r <= abort_nxt;
            own_r <= cpu_per_req_i;
            irq_r <= irq_nxt;
            vld_r <= vld_nxt;
            vec_r <= vec_nxt;
            err_r <= err_nxt;
        end
    end

    assign bus_addr_o = addr_r;
    assign bus_wdata_o = wd_r;
    assign bus_rd_o = rd_r;
    assign bus_wr_o = wr_r;
    assign bus_byte_o = byte_r;
    assign bus_per_o = per_r;
    assign cpu_own_o = own_r;
    assign irq_o = irq_r;
    assign irq_vld_o = vld_r;
    assign irq_vec_o = vec_r;
    assign lim_err_o = err_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_CPU_FIRST: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (bus_rd_o || bus_wr_o) && bus_per_o |-> !$past(cpu_per_req_i))
        else $error("peripheral access while CPU owns the bus");
    AST_ONE_STROBE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bus_rd_o |=> !bus_rd_o && !bus_wr_o ##1 !bus_rd_o && !bus_wr_o)
        else $error("read not followed by latch gap");
    AST_LOWEST: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_r == dmac_pkg::ST_IDLE && !step_r && !abort_r && req_v[0] && !blk_v[0]
        |=> ch_r == 3'h0)
        else $error("channel 0 not granted first");
    AST_BYTE_LANE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bus_wr_o && bus_byte_o |-> bus_wdata_o[15:8] == 8'h00)
        else $error("byte write with upper lane set");
    AST_NULL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_r == dmac_pkg::ST_NUL |-> bus_wr_o && bus_per_o && bus_wdata_o == 16'h0000)
        else $error("null write malformed");
    AST_LIMIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bus_rd_o && !bus_per_o |->
        bus_addr_o >= $past(lim_lo_i) && bus_addr_o <= $past(lim_hi_i))
        else $error("SRAM read outside limits");
    AST_VEC_CH0: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_o[0] |-> irq_vld_o && irq_vec_o == `DMAC_VEC_CH0)
        else $error("channel 0 vector wrong");
    AST_VEC_CH5: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_o == 6'h20 |-> irq_vld_o && irq_vec_o == `DMAC_VEC_CH5)
        else $error("channel 5 vector wrong");
    AST_STEP_AFTER_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        step_r |-> $past(bus_wr_o))
        else $error("step without a completed write");
endmodule

//--- dv/dmac_mem_model.sv
// Far-side memory model: data SRAM and peripheral register space
`timescale 1ns/1ps
module dmac_mem_model (
    input wire logic clk_i,          // System clock
    input wire logic [15:0] addr_i,  // Access address
    input wire logic [15:0] wdata_i, // Write data
    input wire logic rd_i,           // Read strobe
    input wire logic wr_i,           // Write strobe
    input wire logic byte_i,         // Byte access, low lane
    input wire logic per_i,          // Peripheral space select
    output logic [15:0] rdata_o      // Read data, next cycle
);
    // ------------------------------------------------------------
    // Storage, word per location
    // ------------------------------------------------------------
    logic [15:0] mem [512];
    logic [8:0] idx;
    assign idx = {per_i, addr_i[8:1]};
    initial begin
        rdata_o = 16'h0000;
        for (int i = 0; i < 512; i++) begin
            mem[i] = 16'h1000 + i[15:0];
        end
    end
    always @(posedge clk_i) begin
        // Data not held after the read cycle, so a late sample shows
        rdata_o <= rd_i ? mem[idx] : ~rdata_o;
        if (wr_i) begin
            mem[idx] <= byte_i ? {mem[idx][15:8], wdata_i[7:0]} : wdata_i;
        end
    end
endmodule

//--- dv/dmac_core_tb.sv
// Self-checking testbench of the six-channel DMA controller
`timescale 1ns/1ps
module dmac_core_tb;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    localparam int N = 6;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [N-1:0] ch_en = '0, sw_trig = '0, per_trig = '0, word = '0, nul = '0, hie = '0;
    logic [N-1:0][1:0] xmode = '0, dmode = '0;
    logic [N-1:0][2:0] sam = '0, dam = '0;
    logic [N-1:0][15:0] src0 = '0, dst0 = '0, cnt0 = '0, poff = '0;
    logic [15:0] lim_lo = 16'h0000, lim_hi = 16'h00ff, rdata, addr, wdata, first_rd, rd_cnt, b;
    logic cpu_req = 1'b0, rd, wr, bbyte, per, own, ivld;
    logic [N-1:0] irq, lerr;
    logic [6:0] vec;
    logic [1:0] xm = 2'b01;
    logic [2:0] am_s = 3'd1, am_d = 3'd1;
    logic [15:0] irq_cnt [N] = '{default: 16'h0000};
    logic [15:0] lerr_cnt [N] = '{default: 16'h0000};
    logic [6:0] vtab [N] = '{7'h04, 7'h0e, 7'h18, 7'h24, 7'h2e, 7'h3d};
    int n_fail = 0, n_checks = 0;

    always #50 clk_i = ~clk_i;

    dmac_core #(.N(N)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ch_en_i(ch_en),
        .sw_trig_i(sw_trig), .per_trig_i(per_trig), .word_i(word), .null_i(nul), .hie_i(hie),
        .xmode_i(xmode), .dmode_i(dmode), .sam_i(sam), .dam_i(dam), .src0_i(src0),
        .dst0_i(dst0), .cnt0_i(cnt0), .poff_i(poff), .lim_lo_i(lim_lo), .lim_hi_i(lim_hi),
        .cpu_per_req_i(cpu_req), .bus_rdata_i(rdata), .bus_addr_o(addr), .bus_wdata_o(wdata),
        .bus_rd_o(rd), .bus_wr_o(wr), .bus_byte_o(bbyte), .bus_per_o(per), .cpu_own_o(own),
        .irq_o(irq), .irq_vld_o(ivld), .irq_vec_o(vec), .lim_err_o(lerr));

    dmac_mem_model mem_u (.clk_i(clk_i), .addr_i(addr), .wdata_i(wdata), .rd_i(rd),
        .wr_i(wr), .byte_i(bbyte), .per_i(per), .rdata_o(rdata));

    always @(posedge clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (irq[c] === 1'b1) irq_cnt[c]++;
            if (lerr[c] === 1'b1) lerr_cnt[c]++;
        end
        if (rd === 1'b1) begin
            if (rd_cnt == 16'h0000) first_rd = addr;
            rd_cnt++;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Config changes only while the channel is off
    task automatic arm(input int c, input logic [15:0] s, d, n, input logic [1:0] dm,
                       input logic w, nl, h);
        @(negedge clk_i);
        ch_en[c] = 1'b0;
        src0[c] = s;
        dst0[c] = d;
        cnt0[c] = n;
        dmode[c] = dm;
        word[c] = w;
        nul[c] = nl;
        hie[c] = h;
        xmode[c] = xm;
        sam[c] = am_s;
        dam[c] = am_d;
        repeat (2) @(negedge clk_i);
        ch_en[c] = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask

    // Trigger pulse, then a bound that covers the block
    task automatic go(input logic [N-1:0] m, input logic pt, input int w);
        @(negedge clk_i);
        rd_cnt = 16'h0000;
        if (pt) per_trig = m;
        else sw_trig = m;
        @(negedge clk_i);
        sw_trig = '0;
        per_trig = '0;
        repeat (w) @(negedge clk_i);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rd_cnt = 16'h0000;
        repeat (2) @(negedge clk_i);
        check("outputs in reset", {12'h000, rd, wr, ivld, own}, 16'h0000);
        sys_rst_i = 1'b0;
        arm(0, 16'h0010, 16'h0020, 16'h0003, 2'b10, 1'b1, 1'b0, 1'b0);
        go(6'h01, 1'b0, 40);
        for (int k = 0; k < 3; k++) begin
            check("word copy", mem_u.mem[272 + k], 16'h1008 + k[15:0]);
        end
        check("block irq", irq_cnt[0], 16'h0001);
        for (int c = 0; c < N; c++) begin
            b = irq_cnt[c];
            arm(c, 16'h0040, 16'h0080 + 16'(2 * c), 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
            go(6'(1 << c), c[0], 20);
            check("vector", {9'h000, vec}, {9'h000, vtab[c]});
            check("channel irq", irq_cnt[c], b + 16'h0001);
        end
        b = irq_cnt[1];
        arm(1, 16'h0040, 16'h00a0, 16'h0004, 2'b00, 1'b1, 1'b0, 1'b1);
        go(6'h02, 1'b0, 60);
        check("half and full irq", irq_cnt[1], b + 16'h0002);
        arm(2, 16'h0050, 16'h00c0, 16'h0001, 2'b00, 1'b0, 1'b0, 1'b0);
        go(6'h04, 1'b1, 20);
        check("byte copy", mem_u.mem[96], 16'h1028);
        lim_lo = 16'h0010;
        arm(3, 16'h0008, 16'h00e0, 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
        go(6'h08, 1'b0, 20);
        check("limit abort", lerr_cnt[3], 16'h0001);
        check("no access on abort", rd_cnt, 16'h0000);
        lim_lo = 16'h0000;
        arm(4, 16'h0030, 16'h00d0, 16'h0001, 2'b01, 1'b1, 1'b1, 1'b0);
        go(6'h10, 1'b0, 20);
        check("null source copy", mem_u.mem[104], 16'h1118);
        check("null dummy write", mem_u.mem[280], 16'h0000);
        arm(3, 16'h0080, 16'h00b0, 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
        arm(2, 16'h0090, 16'h00b4, 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
        go(6'h0c, 1'b1, 30);
        check("lowest first", first_rd, 16'h0090);
        cpu_req = 1'b1;
        arm(0, 16'h0060, 16'h00e0, 16'h0001, 2'b01, 1'b1, 1'b0, 1'b0);
        arm(1, 16'h0070, 16'h00f0, 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
        b = irq_cnt[0];
        go(6'h03, 1'b0, 20);
        check("cpu keeps bus", {15'h0000, own}, 16'h0001);
        check("sram beside cpu", first_rd, 16'h0070);
        check("held channel", irq_cnt[0], b);
        cpu_req = 1'b0;
        go(6'h00, 1'b0, 20);
        check("released channel", irq_cnt[0], b + 16'h0001);
        // Decrementing source into a fixed destination, one trigger
        am_s = 3'd2;
        am_d = 3'd0;
        arm(5, 16'h0046, 16'h00b8, 16'h0002, 2'b00, 1'b1, 1'b0, 1'b0);
        go(6'h20, 1'b0, 30);
        check("fixed after decrement", mem_u.mem[92], 16'h1022);
        check("continuous reads", rd_cnt, 16'h0002);
        // Repeat keeps the channel armed; reload and indirect pointers
        xm = 2'b10;
        am_s = 3'd3;
        am_d = 3'd4;
        poff[5] = 16'h0002;
        arm(5, 16'h0030, 16'h00c4, 16'h0001, 2'b00, 1'b1, 1'b0, 1'b0);
        b = irq_cnt[5];
        go(6'h20, 1'b1, 20);
        go(6'h20, 1'b0, 20);
        check("repeat rearms", irq_cnt[5], b + 16'h0002);
        check("source reload", first_rd, 16'h0030);
        check("indirect destination", mem_u.mem[99], 16'h1018);
        conclude();
    end
endmodule
